// *** verilog/pwt_pkg.sv ***
// Shared constants, types and decode for the port-mapped supervision timer
package pwt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Host I/O port map
   localparam logic [15:0] PWT_CFG_PORT  = 16'h00f2;

   // Control byte layout and register reset values
   localparam int          PWT_EN_BIT    = 7;
   localparam int          PWT_SEL_LSB   = 0;
   localparam int          PWT_SEL_W     = 4;
   localparam logic [7:0]  PWT_CTRL_RST  = 8'h00;
   localparam logic [7:0]  PWT_COUNT_RST = 8'h00;
   localparam logic [7:0]  PWT_RDATA_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Interval table: code 0 and unlisted codes give the longest interval
   localparam logic [7:0]  PWT_LONG_S    = 8'hff;
   localparam logic [3:0]  PWT_POW_FIRST = 4'h1;
   localparam logic [3:0]  PWT_POW_LAST  = 4'h8;
   localparam logic [7:0]  PWT_ONE_S     = 8'h01;

   ////////////////////////////////////////////////////////////////////////
   // Time base: one second at the 50 MHz system clock
   localparam int unsigned PWT_CLK_HZ    = 50_000_000;
   localparam int unsigned PWT_TIMEBASE_S = 1;
   localparam int unsigned PWT_CYC_PER_S = PWT_CLK_HZ * PWT_TIMEBASE_S;

   ////////////////////////////////////////////////////////////////////////
   // One host I/O cycle, strobes are one clock wide on clk
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } pwt_io_req_t;

   // Seconds for an interval-select code
   function automatic logic [7:0] pwt_interval(input logic [3:0] sel);
      logic [7:0] secs;
      secs = PWT_LONG_S;
      if (sel >= PWT_POW_FIRST && sel <= PWT_POW_LAST) begin
         secs = PWT_ONE_S << (sel - PWT_POW_FIRST);
      end
      return secs;
   endfunction

endpackage

// *** verilog/pwt_sec_tick.sv ***
// One-second tick generator for the supervision timer
module pwt_sec_tick #(
   parameter int unsigned CYC = pwt_pkg::PWT_CYC_PER_S
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // Control and tick
   input  wire logic restart,
   output logic      tick
);
   import pwt_pkg::*;

   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   wire  logic  at_end = (cnt_q == 32'(CYC - 1));

   // Restart keeps a fresh interval a full number of seconds long
   assign tick  = clk_en & at_end & ~restart;
   assign cnt_d = (restart | at_end) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 32'h0000_0000;
      end else if (clk_en) begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// *** verilog/pwt_supervision_timer.sv ***
// Port-mapped supervision timer: control byte, countdown, reset request
//
// How it works
// - Port write loads control byte and reloads counter.
// - Port read reloads counter to interval.
// - Enabled timer counts down, restarts on service.
// - Reaching zero unserviced raises system reset.
// - Bit 7 enables, zero disables.
// - Bits 3..0 select interval; zero means 255s.
// - Intervals 1,2,4,...,128 and 255 seconds.
// - Control byte is zero after reset.
// - Written settings take effect right after write.
module pwt_supervision_timer #(
   parameter int unsigned CYC_PER_S = pwt_pkg::PWT_CYC_PER_S
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   // Host I/O port
   input  wire pwt_pkg::pwt_io_req_t io_req,
   output logic [7:0]                io_rdata,
   // System reset request
   output logic                      sys_reset_req
);
   import pwt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       fired_q;
   logic       fired_d;
   logic       sec_tick;

   ////////////////////////////////////////////////////////////////////////
   // Port decode
   wire logic       port_hit = (io_req.addr == PWT_CFG_PORT);
   wire logic       wr_hit   = clk_en & port_hit & io_req.wr;
   wire logic       rd_hit   = clk_en & port_hit & io_req.rd;
   wire logic       restart  = wr_hit | rd_hit;

   wire logic       timer_enable_bit = ctrl_q[PWT_EN_BIT];
   wire logic [3:0] interval_select_field = ctrl_q[PWT_SEL_LSB +: PWT_SEL_W];
   wire logic [3:0] new_select = io_req.wdata[PWT_SEL_LSB +: PWT_SEL_W];

   wire logic [7:0] interval_now = pwt_interval(interval_select_field);
   wire logic [7:0] interval_new = pwt_interval(new_select);

   wire logic expire = timer_enable_bit & sec_tick & ~restart &
                       (count_q == PWT_ONE_S);
   wire logic step   = timer_enable_bit & sec_tick & ~restart &
                       (count_q != PWT_COUNT_RST);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   // control byte load
   assign ctrl_d  = wr_hit ? io_req.wdata : ctrl_q;
   assign count_d = wr_hit ? interval_new :
                    rd_hit ? interval_now :
                    step   ? count_q - PWT_ONE_S : count_q;
   // Request holds until the system reset it asks for arrives
   assign fired_d = fired_q | expire;
   assign rdata_d = rd_hit ? count_q : rdata_q;

   assign io_rdata      = rdata_q;
   assign sys_reset_req = fired_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q  <= PWT_CTRL_RST;
         count_q <= PWT_COUNT_RST;
         rdata_q <= PWT_RDATA_RST;
         fired_q <= 1'b0;
      end else if (clk_en) begin
         ctrl_q  <= ctrl_d;
         count_q <= count_d;
         rdata_q <= rdata_d;
         fired_q <= fired_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Seconds time base, restarted with every port access
   pwt_sec_tick #(
      .CYC     (CYC_PER_S)
   ) i_pwt_sec_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .restart (restart),
      .tick    (sec_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_ctrl_load;
      wr_hit |=> ctrl_q == $past(io_req.wdata);
   endproperty
   a_ctrl_load: assert property (p_ctrl_load)
      else $error("control byte not loaded by port write");

   property p_ctrl_hold;
      !wr_hit |=> ctrl_q == $past(ctrl_q);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control byte changed without port write");

   property p_service;
      rd_hit && !wr_hit
      |=> count_q == pwt_interval($past(interval_select_field));
   endproperty
   a_service: assert property (p_service)
      else $error("service read did not reload counter");

   property p_count_down;
      !sys_reset_req && clk_en && timer_enable_bit && sec_tick &&
      !restart && count_q > 8'h01
      |=> count_q == $past(count_q) - 8'h01 && !sys_reset_req;
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("enabled counter did not step down one second");

   property p_expire;
      clk_en && timer_enable_bit && sec_tick && !restart && count_q == 8'h01
      |=> sys_reset_req && count_q == 8'h00 ##1 sys_reset_req;
   endproperty
   a_expire: assert property (p_expire)
      else $error("expiry did not raise system reset request");

   property p_no_false_fire;
      $rose(sys_reset_req) |-> $past(count_q) == 8'h01 &&
                               $past(timer_enable_bit) && $past(sec_tick);
   endproperty
   a_no_false_fire: assert property (p_no_false_fire)
      else $error("reset request without expiry");

   property p_disabled_hold;
      !timer_enable_bit && !restart |=> count_q == $past(count_q);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("disabled timer counted");

   property p_zero_code;
      interval_select_field == 4'h0 |-> interval_now == 8'hff;
   endproperty
   a_zero_code: assert property (p_zero_code)
      else $error("code zero not 255 seconds");

   property p_pow_codes;
      interval_select_field inside {[4'h1:4'h8]}
      |-> interval_now == (8'h01 << (interval_select_field - 4'h1));
   endproperty
   a_pow_codes: assert property (p_pow_codes)
      else $error("interval table wrong for power code");

   property p_high_codes;
      interval_select_field > 4'h8 |-> interval_now == 8'hff;
   endproperty
   a_high_codes: assert property (p_high_codes)
      else $error("unlisted code not 255 seconds");

   property p_reset_vals;
      $past(sys_rst) |-> ctrl_q == 8'h00 && !sys_reset_req;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("control byte not zero after reset");

   property p_write_start;
      wr_hit |=> count_q == pwt_interval($past(new_select)) &&
                 timer_enable_bit == $past(io_req.wdata[7]);
   endproperty
   a_write_start: assert property (p_write_start)
      else $error("written settings not applied");

   property p_rdata_capture;
      rd_hit |=> io_rdata == $past(count_q);
   endproperty
   a_rdata_capture: assert property (p_rdata_capture)
      else $error("read data did not capture the count");

   property p_rdata_hold;
      !rd_hit |=> io_rdata == $past(io_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a port read");

   property p_fire_hold;
      sys_reset_req |=> sys_reset_req;
   endproperty
   a_fire_hold: assert property (p_fire_hold)
      else $error("reset request dropped before system reset");

   property p_tick_restart;
      restart |=> !sec_tick;
   endproperty
   a_tick_restart: assert property (p_tick_restart)
      else $error("second tick right after a port access");

   property p_disabled_quiet;
      !timer_enable_bit |=> !$rose(sys_reset_req);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("disabled timer raised a reset request");

   c_enable:  cover property (wr_hit && io_req.wdata[7]);
   c_service: cover property (timer_enable_bit && rd_hit);
   c_expire:  cover property ($rose(sys_reset_req));
   c_disable: cover property (timer_enable_bit && wr_hit && !io_req.wdata[7]);

endmodule

// *** verification/pwt_supervision_timer_test.sv ***
// Self-checking bench for the port-mapped supervision timer
module pwt_supervision_timer_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pwt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Short second keeps the 255 s case to about a thousand cycles
   localparam int unsigned CYC   = 4;
   localparam int          LIMIT = 6000;

   logic        clk;
   logic        sys_rst;
   logic        clk_en;
   pwt_io_req_t io_req;
   logic [7:0]  io_rdata;
   logic        sys_reset_req;
   int          n_fail;
   int          n_checks;
   int          cyc;

   pwt_supervision_timer #(.CYC_PER_S(CYC)) i_pwt_supervision_timer (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .clk_en        (clk_en),
      .io_req        (io_req),
      .io_rdata      (io_rdata),
      .sys_reset_req (sys_reset_req)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Reporting
   task automatic wrap_up();
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Hang guard
   initial begin
      cyc = 0;
      forever begin
         @(posedge clk);
         cyc++;
         if (cyc > LIMIT) begin
            n_fail++;
            wrap_up();
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host port access: inputs move 1 ns past edge; step drops the strobes
   task automatic step(input int n);
      io_req.wr = 1'b0;
      io_req.rd = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic io_op(input logic [15:0] a, input logic w, input logic r,
                        input logic [7:0] d);
      io_req.addr  = a;
      io_req.wr    = w;
      io_req.rd    = r;
      io_req.wdata = d;
      @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] exp);
      io_op(16'h00f2, 1'b0, 1'b1, 8'h00);
      chk("read data", io_rdata, exp);
   endtask

   // Request must stay low until the interval ends, then rise promptly
   task automatic expect_trip(input int secs);
      step(secs * CYC - 1);
      chk("early request", {7'h00, sys_reset_req}, 8'h00);
      step(1);
      chk("request", {7'h00, sys_reset_req}, 8'h01);
   endtask

   task automatic do_reset();
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
   endtask

   // Independent interval table
   function automatic logic [7:0] exp_secs(input int k);
      return (k >= 1 && k <= 8) ? (8'h01 << (k - 1)) : 8'hff;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      n_fail   = 0;
      n_checks = 0;
      clk_en   = 1'b1;
      io_req.addr  = 16'h0000;
      io_req.wdata = 8'h00;
      do_reset();
      chk("reset request", {7'h00, sys_reset_req}, 8'h00);
      step(20);
      chk("idle request", {7'h00, sys_reset_req}, 8'h00);
      rd_chk(8'h00);
      // Disabled timer keeps the freshly written interval frozen
      for (int k = 0; k < 16; k++) begin
         io_op(16'h00f2, 1'b1, 1'b0, 8'(k));
         step(10);
         rd_chk(exp_secs(k));
      end
      io_op(16'h00f3, 1'b1, 1'b0, 8'h81);
      step(10);
      rd_chk(8'hff);
      clk_en = 1'b0;
      io_op(16'h00f2, 1'b1, 1'b0, 8'h81);
      clk_en = 1'b1;
      step(10);
      rd_chk(8'hff);
      io_op(16'h00f2, 1'b1, 1'b0, 8'h81);
      expect_trip(1);
      step(10);
      chk("held request", {7'h00, sys_reset_req}, 8'h01);
      do_reset();
      chk("cleared request", {7'h00, sys_reset_req}, 8'h00);
      // Clearing read before enabling, as host software should
      rd_chk(8'h00);
      // Servicing reads restart the countdown every time
      io_op(16'h00f2, 1'b1, 1'b0, 8'h82);
      for (int i = 0; i < 5; i++) begin
         step(5);
         rd_chk(8'h01);
         chk("served", {7'h00, sys_reset_req}, 8'h00);
      end
      expect_trip(2);
      do_reset();
      io_op(16'h00f2, 1'b1, 1'b0, 8'h81);
      io_op(16'h00f2, 1'b1, 1'b0, 8'h01);
      step(20);
      chk("disabled", {7'h00, sys_reset_req}, 8'h00);
      io_op(16'h00f2, 1'b1, 1'b0, 8'h80);
      expect_trip(255);
      wrap_up();
   end
endmodule
